// ==== rtl/cc_pkg.sv ====
// Constants, register map and types shared by the capture/compare array.
package cc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_MODULES = 3;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PIN_STATE = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MOD_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MOD_STRIDE = 8'h10;
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_LOW = 4'h4;
  localparam logic [3:0] OFS_HIGH = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_GLOBAL_IRQ_BIT = 0;
  localparam int CTRL_ARRAY_IRQ_BIT = 1;
  localparam logic [BYTE_W-1:0] MODE_RESET = 8'h00;
  localparam logic [CNT_W-1:0] VALUE_RESET = 16'h0000;
  localparam logic [NUM_MODULES-1:0] MASK_RESET = 3'h7;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wide_waveform_select;
    logic comparator_enable;
    logic capture_rising_enable;
    logic capture_falling_enable;
    logic compare_hit_enable;
    logic output_flip_on_hit;
    logic waveform_enable;
    logic module_irq_enable;
  } mode_reg_t;

  typedef enum logic [6:0] {
    MODE_IDLE = 7'b0000001,
    MODE_CAPTURE = 7'b0000010,
    MODE_SW_TIMER = 7'b0000100,
    MODE_HS_OUT = 7'b0001000,
    MODE_FREQ_OUT = 7'b0010000,
    MODE_PWM8 = 7'b0100000,
    MODE_WIDE_WAVEFORM_SELECT = 7'b1000000
  } cc_mode_t;

  // Decodes the operating mode of one module from its mode register.
  function automatic cc_mode_t decode_mode(input mode_reg_t m);
    cc_mode_t r;
    r = MODE_IDLE;
    if (!m.compare_hit_enable && !m.output_flip_on_hit && !m.waveform_enable &&
        (m.capture_rising_enable || m.capture_falling_enable)) begin
      r = MODE_CAPTURE;
    end else if (m.comparator_enable && !m.capture_rising_enable &&
                 !m.capture_falling_enable) begin
      if (m.waveform_enable && m.output_flip_on_hit) begin
        r = MODE_FREQ_OUT;
      end else if (m.waveform_enable) begin
        r = m.wide_waveform_select ? MODE_WIDE_WAVEFORM_SELECT : MODE_PWM8;
      end else if (m.compare_hit_enable && m.output_flip_on_hit) begin
        r = MODE_HS_OUT;
      end else if (m.compare_hit_enable) begin
        r = MODE_SW_TIMER;
      end
    end
    return r;
  endfunction

endpackage

// ==== rtl/pin_level_filter.sv ====
// Qualifies a module pin level held two clocks and flags its edges.
`timescale 1ns/10ps
`default_nettype none
module pin_level_filter
  import cc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level_q,
  output logic rise_q,
  output logic fall_q
);

  logic sample_q;

  // ----------------------------------------------------------------
  // Level qualification
  // ----------------------------------------------------------------
  // A new level is accepted only after it was seen on two clock edges.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sample_q <= pin;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (pin == sample_q && pin != level_q) begin
        level_q <= pin;
        rise_q <= pin;
        fall_q <= ~pin;
      end
    end
  end

endmodule // pin_level_filter
`default_nettype wire

// ==== rtl/compare_hit_detect.sv ====
// Flags the first cycle of a counter-to-compare match.
`timescale 1ns/10ps
`default_nettype none
module compare_hit_detect
  import cc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [CNT_W-1:0] compare_value,
  output logic hit_q
);

  logic equal_q;
  logic equal;

  assign equal = enable && (counter_value == compare_value);

  // ----------------------------------------------------------------
  // Match edge
  // ----------------------------------------------------------------
  // A counter that dwells on the compare value yields one hit only.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      equal_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      equal_q <= equal;
      hit_q <= equal && !equal_q;
    end
  end

endmodule // compare_hit_detect
`default_nettype wire

// ==== rtl/capture_compare_array.sv ====
// Capture/compare modules of the counter array with an AHB-Lite slave.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module capture_compare_array
  import cc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [NUM_MODULES-1:0] module_io_pin_in,
  output logic [NUM_MODULES-1:0] module_io_pin_out,
  output logic [NUM_MODULES-1:0] module_io_pin_oe_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  mode_reg_t module_mode_register_q [NUM_MODULES];
  logic [CNT_W-1:0] capture_value_q [NUM_MODULES];
  logic [NUM_MODULES-1:0] module_event_flag_q;
  logic [NUM_MODULES-1:0] irq_mask_q;
  logic global_irq_enable_q;
  logic counter_array_irq_enable_q;

  // ----------------------------------------------------------------
  // Bus pipeline state
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;

  // ----------------------------------------------------------------
  // Per-module signals
  // ----------------------------------------------------------------
  cc_mode_t mode [NUM_MODULES];
  logic [NUM_MODULES-1:0] pin_level;
  logic [NUM_MODULES-1:0] pin_rise;
  logic [NUM_MODULES-1:0] pin_fall;
  logic [NUM_MODULES-1:0] hit;
  logic [NUM_MODULES-1:0] capture_event;
  logic [NUM_MODULES-1:0] compare_event;
  logic [NUM_MODULES-1:0] irq_enable_vec;
  logic [NUM_MODULES-1:0] pin_out_q;
  logic [NUM_MODULES-1:0] pin_oe_n_q;
  logic irq_q;

  logic addr_phase;
  logic [NUM_MODULES-1:0] flag_clear;
  logic [NUM_MODULES-1:0] module_request;
  logic [NUM_MODULES-1:0] hs_toggle;
  logic hresp_q;

  // Per-register write strobes, valid in the data phase of a write.
  logic wr_status;
  logic wr_mask;
  logic wr_control;
  logic [NUM_MODULES-1:0] wr_mode;
  logic [NUM_MODULES-1:0] wr_low;
  logic [NUM_MODULES-1:0] wr_high;

  // Address of a given register of module n.
  function automatic logic [ADDR_W-1:0] mod_addr(input int n, input logic [3:0] ofs);
    logic [ADDR_W-1:0] base;
    base = ADDR_MOD_BASE + ADDR_W'(n) * ADDR_MOD_STRIDE;
    return base | {4'h0, ofs};
  endfunction

  // ----------------------------------------------------------------
  // Module datapaths
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_module
    logic hit_enable;

    // Frequency and waveform modes are decoded but drive no waveform here,
    // so their pins stay with the outside world.
    assign mode[i] = decode_mode(module_mode_register_q[i]);

    pin_level_filter u_filter (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin(module_io_pin_in[i]),
      .level_q(pin_level[i]),
      .rise_q(pin_rise[i]),
      .fall_q(pin_fall[i])
    );

    assign hit_enable = module_mode_register_q[i].comparator_enable &&
                        module_mode_register_q[i].compare_hit_enable &&
                        (mode[i] == MODE_SW_TIMER || mode[i] == MODE_HS_OUT);

    // The comparator watches the value register itself; a half-written
    // value is harmless because the low byte write drops the enable.
    compare_hit_detect u_hit (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(hit_enable),
      .counter_value(counter_value),
      .compare_value(capture_value_q[i]),
      .hit_q(hit[i])
    );

    // Capture fires on the edge kinds that the mode register selects.
    assign capture_event[i] = (mode[i] == MODE_CAPTURE) &&
      ((module_mode_register_q[i].capture_rising_enable && pin_rise[i]) ||
       (module_mode_register_q[i].capture_falling_enable && pin_fall[i]));

    assign compare_event[i] = hit[i];
    assign irq_enable_vec[i] = module_mode_register_q[i].module_irq_enable;
    assign hs_toggle[i] = (mode[i] == MODE_HS_OUT) && hit[i];
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Read data is sampled in the address phase and presented in the data phase.
  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ADDR_STATUS: r[NUM_MODULES-1:0] = module_event_flag_q;
      ADDR_MASK: r[NUM_MODULES-1:0] = irq_mask_q;
      ADDR_CONTROL: begin
        r[CTRL_GLOBAL_IRQ_BIT] = global_irq_enable_q;
        r[CTRL_ARRAY_IRQ_BIT] = counter_array_irq_enable_q;
      end
      ADDR_PIN_STATE: r[NUM_MODULES-1:0] = pin_level;
      default: begin
        for (int n = 0; n < NUM_MODULES; n++) begin
          if (a == mod_addr(n, OFS_MODE)) begin
            r[BYTE_W-1:0] = module_mode_register_q[n];
          end
          if (a == mod_addr(n, OFS_LOW)) begin
            r[BYTE_W-1:0] = capture_value_q[n][BYTE_W-1:0];
          end
          if (a == mod_addr(n, OFS_HIGH)) begin
            r[BYTE_W-1:0] = capture_value_q[n][CNT_W-1:BYTE_W];
          end
        end
      end
    endcase
    return r;
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      // The slave never stalls; ready is low only in reset and until the first clock edge after it.
      hreadyout_q <= 1'b1;
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr[ADDR_W-1:0];
      end
      if (addr_phase && !hwrite) begin
        hrdata_q <= read_mux(haddr[ADDR_W-1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  // The response is registered so that every bus output leaves a flop.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hresp_q <= HRESP_OKAY;
    end else begin
      hresp_q <= HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // A read right behind a write still sees the old value, since read
  // data is taken in the address phase and writes land in the data phase.
  always_comb begin
    wr_status = wr_pend_q && (wr_addr_q == ADDR_STATUS);
    wr_mask = wr_pend_q && (wr_addr_q == ADDR_MASK);
    wr_control = wr_pend_q && (wr_addr_q == ADDR_CONTROL);
    for (int n = 0; n < NUM_MODULES; n++) begin
      wr_mode[n] = wr_pend_q && (wr_addr_q == mod_addr(n, OFS_MODE));
      wr_low[n] = wr_pend_q && (wr_addr_q == mod_addr(n, OFS_LOW));
      wr_high[n] = wr_pend_q && (wr_addr_q == mod_addr(n, OFS_HIGH));
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= MASK_RESET;
      global_irq_enable_q <= 1'b0;
      counter_array_irq_enable_q <= 1'b0;
    end else begin
      if (wr_mask) begin
        irq_mask_q <= hwdata[NUM_MODULES-1:0];
      end
      if (wr_control) begin
        global_irq_enable_q <= hwdata[CTRL_GLOBAL_IRQ_BIT];
        counter_array_irq_enable_q <= hwdata[CTRL_ARRAY_IRQ_BIT];
      end
    end
  end

  // Mode registers; compare byte writes also steer the comparator enable.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < NUM_MODULES; n++) begin
        module_mode_register_q[n] <= MODE_RESET;
      end
    end else if (wr_pend_q) begin
      for (int n = 0; n < NUM_MODULES; n++) begin
        if (wr_mode[n]) begin
          module_mode_register_q[n] <= hwdata[BYTE_W-1:0];
        end
        if (wr_low[n]) begin
          module_mode_register_q[n].comparator_enable <= 1'b0;
        end
        if (wr_high[n]) begin
          module_mode_register_q[n].comparator_enable <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture/compare value registers
  // ----------------------------------------------------------------
  // A hardware capture wins over a software byte write in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < NUM_MODULES; n++) begin
        capture_value_q[n] <= VALUE_RESET;
      end
    end else begin
      for (int n = 0; n < NUM_MODULES; n++) begin
        if (capture_event[n]) begin
          capture_value_q[n] <= counter_value;
        end else if (wr_low[n]) begin
          capture_value_q[n][BYTE_W-1:0] <= hwdata[BYTE_W-1:0];
        end else if (wr_high[n]) begin
          capture_value_q[n][CNT_W-1:BYTE_W] <= hwdata[BYTE_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  assign flag_clear = wr_status ?
                      hwdata[NUM_MODULES-1:0] : '0;

  // Flags are sticky; a new event beats a write-one clear.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      module_event_flag_q <= '0;
    end else begin
      module_event_flag_q <= (capture_event | compare_event) |
                             (module_event_flag_q & ~flag_clear);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // A module asks for service while its flag, enable and mask bit are all set.
  assign module_request = module_event_flag_q & irq_enable_vec & irq_mask_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= global_irq_enable_q && counter_array_irq_enable_q &&
               |module_request;
    end
  end

  // ----------------------------------------------------------------
  // Module pins
  // ----------------------------------------------------------------
  // Only high-speed output drives its pin here; other modes leave it free.
  // The enable follows the decoded mode one clock late, so a newly entered
  // mode takes the pin over from the next cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      for (int n = 0; n < NUM_MODULES; n++) begin
        pin_oe_n_q[n] <= (mode[n] != MODE_HS_OUT);
        if (hs_toggle[n]) begin
          pin_out_q[n] <= ~pin_out_q[n];
        end
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign module_io_pin_out = pin_out_q;
  assign module_io_pin_oe_n = pin_oe_n_q;
  assign irq = irq_q;

endmodule // capture_compare_array
`default_nettype wire

// ==== testbench/cc_array_sva.sv ====
// Port-level checker of the capture/compare array.
`timescale 1ns/10ps
`default_nettype none
module cc_array_chk
  import cc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [NUM_MODULES-1:0] module_io_pin_in,
  input wire logic [NUM_MODULES-1:0] module_io_pin_out,
  input wire logic [NUM_MODULES-1:0] module_io_pin_oe_n,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rd_take;
  logic wr_take;
  logic [2:0] prev_q;
  logic [2:0] stab_q;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // Counts how long the pin wires have stood still.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 3'h0;
      stab_q <= 3'h0;
    end else begin
      prev_q <= module_io_pin_in;
      if (module_io_pin_in != prev_q) begin
        stab_q <= 3'h0;
      end else if (stab_q != 3'h7) begin
        stab_q <= stab_q + 3'h1;
      end
    end
  end
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("bus response not okay");
  chk_zero_wait: assert property (!$past(rst) |-> hreadyout)
    else $error("slave inserted a wait state");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_read_stable: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd_take && haddr[7:0] >= 8'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_pin_level: assert property (
    rd_take && haddr[7:0] == ADDR_PIN_STATE && stab_q >= 3'h4
    |=> hrdata == {29'h0, $past(module_io_pin_in, 2)})
    else $error("pin state read wrong");
  chk_ctrl_irq: assert property (
    wr_take && haddr[7:0] == ADDR_CONTROL ##1 hwdata[1:0] != 2'h3 |-> ##2 !irq [*2])
    else $error("irq high with an enable off");
  chk_mask_irq: assert property (
    wr_take && haddr[7:0] == ADDR_MASK ##1 hwdata[2:0] == 3'h0 |-> ##2 !irq [*2])
    else $error("irq high with all masked");
  chk_pin_hold: assert property (
    ($past(module_io_pin_oe_n) & module_io_pin_oe_n
     & (module_io_pin_out ^ $past(module_io_pin_out))) == 3'h0)
    else $error("pin drive moved while not driven");
  cov_irq_rise: cover property ($rose(irq));
  cov_pin_flip: cover property ($changed(module_io_pin_out));
  cov_pin_read: cover property (rd_take && haddr[7:0] == ADDR_PIN_STATE);
endmodule // cc_array_chk
bind capture_compare_array cc_array_chk i_chk (.sys_clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .counter_value,
  .module_io_pin_in, .module_io_pin_out, .module_io_pin_oe_n, .irq);
`default_nettype wire

// ==== testbench/pin_source.sv ====
// Model of the external drivers on the module pins.
`timescale 1ns/10ps
`default_nettype none
module pin_source
  import cc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NUM_MODULES-1:0] want,
  input wire logic [NUM_MODULES-1:0] pin_out,
  input wire logic [NUM_MODULES-1:0] pin_oe_n,
  output logic [NUM_MODULES-1:0] pin_in
);
  logic [NUM_MODULES-1:0] lvl_q;
  logic [1:0] held_q [NUM_MODULES];
  // A new level is taken only once the old one has stood two clocks.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvl_q <= '0;
      for (int i = 0; i < NUM_MODULES; i++) held_q[i] <= 2'h2;
    end else begin
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (want[i] != lvl_q[i] && held_q[i] >= 2'h2) begin
          lvl_q[i] <= want[i];
          held_q[i] <= 2'h1;
        end else if (held_q[i] != 2'h3) begin
          held_q[i] <= held_q[i] + 2'h1;
        end
      end
    end
  end
  // The block owns the wire while its output enable is low.
  assign pin_in = (lvl_q & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule // pin_source
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the capture/compare array.
`timescale 1ns/10ps
`default_nettype none
module tb
  import cc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [CNT_W-1:0] counter_value = 16'h0000;
  logic [2:0] module_io_pin_in;
  logic [2:0] module_io_pin_out;
  logic [2:0] module_io_pin_oe_n;
  logic [2:0] want = 3'h0;
  logic irq;
  logic rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] val [3];
  logic [15:0] t;
  logic [7:0] base;
  logic [1:0] e;
  logic [7:0] wave_modes [3] = '{8'h46, 8'h42, 8'hC2};
  int fails = 0;
  int checks = 0;
  int seed = 32'h44B1;
  assign hready = hreadyout;
  always #2 sys_clk = ~sys_clk;
  capture_compare_array i_dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .counter_value, .module_io_pin_in,
    .module_io_pin_out, .module_io_pin_oe_n, .irq);
  pin_source i_pins (.sys_clk, .rst, .want, .pin_out(module_io_pin_out),
    .pin_oe_n(module_io_pin_oe_n), .pin_in(module_io_pin_in));
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_port(input string nm, input logic [31:0] x, input logic [31:0] got);
    checks++;
    if (got !== x) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    xfer(1'b0, a, 32'h0);
  endtask
  // Read data is compared against the oldest noted expectation.
  always @(posedge sys_clk) begin
    if (rd_ph && hready === 1'b1) cmp_port("hrdata", exp_q.pop_front(), hrdata);
  end
  initial begin
    tick(2);
    rst <= 1'b0;
    tick(2);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_MASK, 32'h7);
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_MOD_BASE, 32'h0);
    rd(8'hFC, 32'h0);
    cmp_port("oe_n", 32'h7, {29'h0, module_io_pin_oe_n});
    wr(ADDR_CONTROL, 32'h3);
    for (int m = 0; m < 3; m++) begin
      e = 2'(m + 1);
      base = 8'(16 + 16 * m);
      val[m] = 16'h0000;
      wr(base, {26'h0, e, 4'h1});
      t = 16'($random(seed));
      counter_value <= t;
      want[m] <= 1'b1;
      tick(8);
      if (e[1]) val[m] = t;
      cmp_port("irq", {31'h0, e[1]}, {31'h0, irq});
      rd(ADDR_STATUS, 32'(e[1]) << m);
      rd(ADDR_PIN_STATE, 32'h1 << m);
      if (m == 2) begin
        wr(ADDR_CONTROL, 32'h1);
        tick(3);
        cmp_port("irq", 32'h0, {31'h0, irq});
        wr(ADDR_CONTROL, 32'h3);
        wr(ADDR_MASK, 32'h0);
        tick(3);
        cmp_port("irq", 32'h0, {31'h0, irq});
        wr(ADDR_MASK, 32'h7);
        tick(3);
        cmp_port("irq", 32'h1, {31'h0, irq});
        wr(base, 32'h30);
        tick(3);
        cmp_port("irq", 32'h0, {31'h0, irq});
        wr(base, 32'h31);
      end
      wr(ADDR_STATUS, 32'h7);
      t = 16'($random(seed));
      counter_value <= t;
      want[m] <= 1'b0;
      tick(8);
      if (e[0]) val[m] = t;
      rd(ADDR_STATUS, 32'(e[0]) << m);
      rd(base + 8'h4, {24'h0, val[m][7:0]});
      rd(base + 8'h8, {24'h0, val[m][15:8]});
      wr(ADDR_STATUS, 32'h7);
    end
    t = 16'($random(seed));
    counter_value <= ~t;
    wr(8'h20, 32'h49);
    wr(8'h24, {24'h0, t[7:0]});
    rd(8'h20, 32'h09);
    counter_value <= {val[1][15:8], t[7:0]};
    tick(6);
    rd(ADDR_STATUS, 32'h0);
    counter_value <= ~t;
    wr(8'h28, {24'h0, t[15:8]});
    rd(8'h20, 32'h49);
    counter_value <= t;
    tick(6);
    rd(ADDR_STATUS, 32'h2);
    cmp_port("irq", 32'h1, {31'h0, irq});
    wr(ADDR_STATUS, 32'h7);
    wr(8'h20, 32'h0);
    t = 16'($random(seed));
    counter_value <= ~t;
    wr(8'h10, 32'h4C);
    wr(8'h14, {24'h0, t[7:0]});
    wr(8'h18, {24'h0, t[15:8]});
    tick(2);
    cmp_port("oe_n", 32'h6, {29'h0, module_io_pin_oe_n});
    for (int k = 1; k < 3; k++) begin
      counter_value <= t;
      tick(6);
      cmp_port("pin_out", 32'(k[0]), {31'h0, module_io_pin_out[0]});
      cmp_port("irq", 32'h0, {31'h0, irq});
      counter_value <= ~t;
      tick(4);
    end
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h7);
    wr(8'h10, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(8'h30, {24'h0, wave_modes[k]});
      counter_value <= val[2];
      tick(6);
      rd(ADDR_STATUS, 32'h0);
      cmp_port("oe_n", 32'h7, {29'h0, module_io_pin_oe_n});
      counter_value <= ~val[2];
    end
    summarize();
  end
  initial begin
    tick(20000);
    fails++;
    summarize();
  end
endmodule // tb
`default_nettype wire
